// [rtl/pcr_pkg.sv]
package pcr_pkg;
	// control port widths
	localparam int unsigned PCR_AW = 8;
	localparam int unsigned PCR_DW = 8;
	// live-update data widths
	localparam int unsigned PCR_VOL_W  = 8;
	localparam int unsigned PCR_COEF_W = 16;
	// pages
	localparam logic [7:0] PCR_PAGE_PROC = 8'h00;
	localparam logic [7:0] PCR_PAGE_AUX  = 8'h01;
	// offsets
	localparam logic [7:0] PCR_OFF_PAGE    = 8'h00;
	localparam logic [7:0] PCR_OFF_PROC    = 8'h03;
	localparam logic [7:0] PCR_OFF_DIAG_HI = 8'h70;
	localparam logic [7:0] PCR_OFF_DIAG_LO = 8'h71;
	localparam logic [7:0] PCR_OFF_BOOST   = 8'h72;
	localparam logic [7:0] PCR_OFF_MICBIAS = 8'h73;
	// reset values
	localparam logic [7:0] PCR_RST_PAGE    = 8'h00;
	localparam logic [7:0] PCR_RST_PROC    = 8'h00;
	localparam logic [7:0] PCR_RST_DIAG_HI = 8'h00;
	localparam logic [7:0] PCR_RST_DIAG_LO = 8'h0D;
	localparam logic [7:0] PCR_RST_BOOST   = 8'h00;
	localparam logic [7:0] PCR_RST_MICBIAS = 8'hA0;
	// processing config fields
	localparam int unsigned PCR_BIT_VOL_BLOCK = 1;
	localparam int unsigned PCR_BIT_FLT_EN    = 0;
	localparam logic [7:0]  PCR_PROC_MASK     = 8'h03;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [PCR_AW-1:0] addr;
		logic [PCR_DW-1:0] wdata;
	} pcr_req_t;

	typedef struct packed {
		logic              valid;
		logic [PCR_DW-1:0] data;
	} pcr_rsp_t;
endpackage

// [rtl/pcr_live_gate.sv]
`timescale 1ns/1ns
module pcr_live_gate #(
	parameter int unsigned W = 8
) (
	// clock, reset, enable
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	// update request
	input  wire logic         req,
	input  wire logic [W-1:0] data,
	input  wire logic         allow,
	// result
	output logic      [W-1:0] value_q,
	output logic              applied_q,
	output logic              refused_q
);
	logic [W-1:0] value_d;
	logic         applied_d;
	logic         refused_d;

	// take the update only while allowed
	always_comb begin
		value_d   = value_q;
		applied_d = 1'b0;
		refused_d = 1'b0;
		if (req && allow) begin
			value_d   = data;
			applied_d = 1'b1;
		end else if (req) begin
			refused_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			value_q   <= '0;
			applied_q <= 1'b0;
			refused_q <= 1'b0;
		end else if (ce) begin
			value_q   <= value_d;
			applied_q <= applied_d;
			refused_q <= refused_d;
		end
	end
endmodule // pcr_live_gate

// [rtl/pcr_bank.sv]
`timescale 1ns/1ns
module pcr_bank
	import pcr_pkg::*;
(
	// clock, reset, enable
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire logic                   ce,
	// serial control side
	input  wire pcr_pkg::pcr_req_t      ctl_req,
	output pcr_pkg::pcr_rsp_t           ctl_rsp,
	// device state
	input  wire logic                   adc_powered,
	input  wire logic                   dsp_running,
	// digital volume updates
	input  wire logic                   vol_req,
	input  wire logic [PCR_VOL_W-1:0]   vol_data,
	output logic      [PCR_VOL_W-1:0]   digital_volume,
	output logic                        vol_applied,
	output logic                        vol_refused,
	// biquad coefficient updates
	input  wire logic                   coef_req,
	input  wire logic [PCR_COEF_W-1:0]  coef_data,
	output logic      [PCR_COEF_W-1:0]  coef_value,
	output logic                        coef_applied,
	output logic                        coef_refused,
	// diagnostic monitor capture
	input  wire logic                   diag_capture,
	input  wire logic [7:0]             diag_hi_in,
	input  wire logic [7:0]             diag_lo_in,
	// configuration outputs
	output logic      [7:0]             active_page,
	output logic                        volume_live_update_block,
	output logic                        filter_live_update_enable,
	output logic      [7:0]             step_up_converter_cfg,
	output logic      [7:0]             mic_bias_cfg
);
	import pcr_pkg::*;

	logic [1:0] rst_sync_q;
	logic       rst_n;
	logic [7:0] page_q;
	logic [7:0] page_d;
	logic [7:0] proc_q;
	logic [7:0] proc_d;
	logic [7:0] diag_hi_q;
	logic [7:0] diag_hi_d;
	logic [7:0] diag_lo_q;
	logic [7:0] diag_lo_d;
	logic [7:0] boost_q;
	logic [7:0] boost_d;
	logic [7:0] micb_q;
	logic [7:0] micb_d;
	pcr_rsp_t   rsp_q;
	pcr_rsp_t   rsp_d;
	logic       vol_allow;
	logic       coef_allow;

	// reset release through two flops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// paged register hit
	function automatic logic hit(input logic [7:0] pg, input logic [7:0] ad,
		input logic [7:0] tpg, input logic [7:0] tad);
		hit = (pg == tpg) && (ad == tad);
	endfunction

	// read mux, zero when unmapped
	function automatic logic [7:0] rd_mux(input logic [7:0] pg,
		input logic [7:0] ad);
		rd_mux = 8'h00;
		if (ad == PCR_OFF_PAGE) begin
			rd_mux = page_q;
		end else if (hit(pg, ad, PCR_PAGE_PROC, PCR_OFF_PROC)) begin
			rd_mux = proc_q & PCR_PROC_MASK;
		end else if (hit(pg, ad, PCR_PAGE_AUX, PCR_OFF_DIAG_HI)) begin
			rd_mux = diag_hi_q;
		end else if (hit(pg, ad, PCR_PAGE_AUX, PCR_OFF_DIAG_LO)) begin
			rd_mux = diag_lo_q;
		end else if (hit(pg, ad, PCR_PAGE_AUX, PCR_OFF_BOOST)) begin
			rd_mux = boost_q;
		end else if (hit(pg, ad, PCR_PAGE_AUX, PCR_OFF_MICBIAS)) begin
			rd_mux = micb_q;
		end
	endfunction

	// register writes and read answer
	always_comb begin
		page_d    = page_q;
		proc_d    = proc_q;
		boost_d   = boost_q;
		micb_d    = micb_q;
		diag_hi_d = diag_hi_q;
		diag_lo_d = diag_lo_q;
		rsp_d     = '0;
		if (diag_capture) begin
			diag_hi_d = diag_hi_in;
			diag_lo_d = diag_lo_in;
		end
		if (ctl_req.wr) begin
			if (ctl_req.addr == PCR_OFF_PAGE) begin
				page_d = ctl_req.wdata;
			end else if (hit(page_q, ctl_req.addr, PCR_PAGE_PROC,
				PCR_OFF_PROC)) begin
				proc_d = ctl_req.wdata & PCR_PROC_MASK;
			end else if (hit(page_q, ctl_req.addr, PCR_PAGE_AUX,
				PCR_OFF_BOOST)) begin
				boost_d = ctl_req.wdata;
			end else if (hit(page_q, ctl_req.addr, PCR_PAGE_AUX,
				PCR_OFF_MICBIAS)) begin
				micb_d = ctl_req.wdata;
			end
		end
		if (ctl_req.rd) begin
			rsp_d.valid = 1'b1;
			rsp_d.data  = rd_mux(page_q, ctl_req.addr);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			page_q    <= PCR_RST_PAGE;
			proc_q    <= PCR_RST_PROC;
			diag_hi_q <= PCR_RST_DIAG_HI;
			diag_lo_q <= PCR_RST_DIAG_LO;
			boost_q   <= PCR_RST_BOOST;
			micb_q    <= PCR_RST_MICBIAS;
			rsp_q     <= '0;
		end else if (ce) begin
			page_q    <= page_d;
			proc_q    <= proc_d;
			diag_hi_q <= diag_hi_d;
			diag_lo_q <= diag_lo_d;
			boost_q   <= boost_d;
			micb_q    <= micb_d;
			rsp_q     <= rsp_d;
		end
	end

	// live-update permissions
	assign vol_allow  = !proc_q[PCR_BIT_VOL_BLOCK] || !adc_powered;
	assign coef_allow = proc_q[PCR_BIT_FLT_EN] || !dsp_running;

	pcr_live_gate #(
		.W (PCR_VOL_W)
	) u_vol_gate (
		.clk       (clk),
		.rst_n     (rst_n),
		.ce        (ce),
		.req       (vol_req),
		.data      (vol_data),
		.allow     (vol_allow),
		.value_q   (digital_volume),
		.applied_q (vol_applied),
		.refused_q (vol_refused)
	);

	pcr_live_gate #(
		.W (PCR_COEF_W)
	) u_coef_gate (
		.clk       (clk),
		.rst_n     (rst_n),
		.ce        (ce),
		.req       (coef_req),
		.data      (coef_data),
		.allow     (coef_allow),
		.value_q   (coef_value),
		.applied_q (coef_applied),
		.refused_q (coef_refused)
	);

	assign ctl_rsp                   = rsp_q;
	assign active_page               = page_q;
	assign volume_live_update_block  = proc_q[PCR_BIT_VOL_BLOCK];
	assign filter_live_update_enable = proc_q[PCR_BIT_FLT_EN];
	assign step_up_converter_cfg     = boost_q;
	assign mic_bias_cfg              = micb_q;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_page_wr;
		ce && ctl_req.wr && ctl_req.addr == PCR_OFF_PAGE;
	endsequence

	sequence s_proc_rd;
		ce && ctl_req.rd && !ctl_req.wr && page_q == PCR_PAGE_PROC &&
			ctl_req.addr == PCR_OFF_PROC;
	endsequence

	property p_page_any;
		s_page_wr |=> page_q == $past(ctl_req.wdata);
	endproperty
	a_page_any: assert property (p_page_any)
		else $error("page select write lost");

	property p_page_hold;
		(!ce || !ctl_req.wr || ctl_req.addr != PCR_OFF_PAGE) |=>
			$stable(page_q);
	endproperty
	a_page_hold: assert property (p_page_hold)
		else $error("page select changed without write");

	property p_paged;
		(ce && ctl_req.wr && ctl_req.addr == PCR_OFF_PROC &&
			page_q != PCR_PAGE_PROC) |=> $stable(proc_q);
	endproperty
	a_paged: assert property (p_paged)
		else $error("processing config written on wrong page");

	property p_rsv_rd;
		s_proc_rd |=> ctl_rsp.valid && ctl_rsp.data[7:2] == 6'h00 &&
			ctl_rsp.data[1:0] == proc_q[1:0];
	endproperty
	a_rsv_rd: assert property (p_rsv_rd)
		else $error("processing config read wrong");

	property p_vol_block;
		(ce && vol_req && volume_live_update_block && adc_powered) |=>
			vol_refused && !vol_applied && $stable(digital_volume);
	endproperty
	a_vol_block: assert property (p_vol_block)
		else $error("volume changed while blocked");

	property p_vol_ok;
		(ce && vol_req && !(volume_live_update_block && adc_powered)) |=>
			vol_applied && digital_volume == $past(vol_data);
	endproperty
	a_vol_ok: assert property (p_vol_ok)
		else $error("volume change not applied");

	property p_flt_off;
		(ce && coef_req && dsp_running && !filter_live_update_enable) |=>
			coef_refused && $stable(coef_value);
	endproperty
	a_flt_off: assert property (p_flt_off)
		else $error("coefficient changed while disabled");

	property p_flt_on;
		(ce && coef_req && filter_live_update_enable) |=>
			coef_applied && coef_value == $past(coef_data);
	endproperty
	a_flt_on: assert property (p_flt_on)
		else $error("coefficient change not applied");
endmodule // pcr_bank

// [test/pcr_host.sv]
`timescale 1ns/1ns
module pcr_host
	import pcr_pkg::*;
(
	// clock
	input  wire logic              clk,
	// control port
	output pcr_pkg::pcr_req_t      ctl_req,
	input  wire pcr_pkg::pcr_rsp_t ctl_rsp
);
	import pcr_pkg::*;
	initial ctl_req = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = (a == PCR_OFF_PROC) ? (d & PCR_PROC_MASK) : d;
		@(posedge clk);
		#1 ctl_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge clk);
		#1 ctl_req = '0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output bit ok);
		int i;
		@(posedge clk);
		#1 ctl_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		#1 ctl_req = '0;
		for (i = 0; i < 3; i++) begin
			if (ctl_rsp.valid === 1'b1)
				break;
			@(posedge clk);
			#1;
		end
		ok = (ctl_rsp.valid === 1'b1);
		d = ctl_rsp.data;
	endtask
endmodule // pcr_host

// [test/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
	import pcr_pkg::*;
	logic        clk, resetn, ce, adc_powered, dsp_running;
	logic        vol_req, coef_req, diag_capture, vblk, fen;
	logic        vol_applied, vol_refused, coef_applied, coef_refused;
	logic [7:0]  vol_data, diag_hi_in, diag_lo_in, digital_volume;
	logic [7:0]  active_page, boost, micbias;
	logic [15:0] coef_data, coef_value;
	pcr_req_t    ctl_req;
	pcr_rsp_t    ctl_rsp;
	int          n_fail, num_checks;

	pcr_bank dut (.clk(clk), .resetn(resetn), .ce(ce),
		.ctl_req(ctl_req), .ctl_rsp(ctl_rsp), .adc_powered(adc_powered),
		.dsp_running(dsp_running), .vol_req(vol_req), .vol_data(vol_data),
		.digital_volume(digital_volume), .vol_applied(vol_applied),
		.vol_refused(vol_refused), .coef_req(coef_req),
		.coef_data(coef_data), .coef_value(coef_value),
		.coef_applied(coef_applied), .coef_refused(coef_refused),
		.diag_capture(diag_capture), .diag_hi_in(diag_hi_in),
		.diag_lo_in(diag_lo_in), .active_page(active_page),
		.volume_live_update_block(vblk),
		.filter_live_update_enable(fen),
		.step_up_converter_cfg(boost), .mic_bias_cfg(micbias));
	pcr_host host (.clk(clk), .ctl_req(ctl_req), .ctl_rsp(ctl_rsp));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rck(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		bit         ok;
		host.rd(a, d, ok);
		if (!ok) begin
			n_fail++;
			close_out();
		end else begin
			chk(d, exp);
		end
	endtask
	task automatic upd(input bit vol, input logic [15:0] v);
		@(posedge clk);
		#1 vol_req = vol;
		coef_req = !vol;
		vol_data = v[7:0];
		coef_data = v;
		@(posedge clk);
		#1 vol_req = 1'b0;
		coef_req = 1'b0;
	endtask
	task automatic t_reset();
		rck(8'h00, 8'h00);
		rck(8'h03, 8'h00);
		host.wr(8'h00, 8'h01);
		rck(8'h70, 8'h00);
		rck(8'h71, 8'h0D);
		rck(8'h72, 8'h00);
		rck(8'h73, 8'hA0);
		chk(micbias, 8'hA0);
		$display("t_reset done");
	endtask
	task automatic t_page();
		host.wr(8'h72, 8'h5A);
		rck(8'h72, 8'h5A);
		chk(boost, 8'h5A);
		host.wr(8'h70, 8'hFF);
		rck(8'h70, 8'h00);
		@(posedge clk);
		#1 diag_hi_in = 8'h12;
		diag_lo_in = 8'h34;
		diag_capture = 1'b1;
		@(posedge clk);
		#1 diag_capture = 1'b0;
		rck(8'h70, 8'h12);
		rck(8'h71, 8'h34);
		rck(8'h03, 8'h00);
		host.wr(8'h03, 8'h03);
		rck(8'h03, 8'h00);
		host.wr(8'h00, 8'hFF);
		chk(active_page, 8'hFF);
		rck(8'h00, 8'hFF);
		rck(8'h72, 8'h00);
		host.wr(8'h00, 8'h00);
		rck(8'h72, 8'h00);
		rck(8'h03, 8'h00);
		host.wr(8'h03, 8'hFF);
		rck(8'h03, 8'h03);
		$display("t_page done");
	endtask
	task automatic t_live();
		host.wr(8'h03, 8'h02);
		chk({vblk, fen}, 2'b10);
		adc_powered = 1'b1;
		dsp_running = 1'b1;
		upd(1'b1, 16'h0005);
		chk({vol_applied, vol_refused, digital_volume}, 16'h0100);
		upd(1'b0, 16'hBEEF);
		chk({coef_applied, coef_refused}, 2'b01);
		chk(coef_value, 16'h0000);
		adc_powered = 1'b0;
		upd(1'b1, 16'h0005);
		chk({vol_applied, vol_refused, digital_volume}, 16'h0205);
		dsp_running = 1'b0;
		upd(1'b0, 16'h1234);
		chk({coef_applied, coef_refused}, 2'b10);
		chk(coef_value, 16'h1234);
		host.wr(8'h03, 8'h01);
		adc_powered = 1'b1;
		dsp_running = 1'b1;
		upd(1'b1, 16'h0009);
		chk({vol_applied, vol_refused, digital_volume}, 16'h0209);
		upd(1'b0, 16'hBEEF);
		chk({coef_applied, coef_refused}, 2'b10);
		chk(coef_value, 16'hBEEF);
		$display("t_live done");
	endtask
	task automatic t_freeze();
		@(posedge clk);
		#1 ce = 1'b0;
		host.wr(8'h00, 8'h07);
		upd(1'b1, 16'h0033);
		chk(active_page, 8'h00);
		chk(digital_volume, 16'h0009);
		@(posedge clk);
		#1 ce = 1'b1;
		rck(8'h00, 8'h00);
		$display("t_freeze done");
	endtask
	task automatic t_rst_mid();
		host.wr(8'h00, 8'h01);
		@(posedge clk);
		#1 resetn = 1'b0;
		@(posedge clk);
		#1 resetn = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk(digital_volume, 16'h0000);
		chk(active_page, 8'h00);
		rck(8'h00, 8'h00);
		rck(8'h03, 8'h00);
		$display("t_rst_mid done");
	endtask
	initial begin
		#200000;
		n_fail++;
		close_out();
	end
	initial begin
		{resetn, adc_powered, dsp_running, vol_req, coef_req} = '0;
		{diag_capture, vol_data, diag_hi_in, diag_lo_in, coef_data} = '0;
		ce = 1'b1;
		n_fail = 0;
		num_checks = 0;
		repeat (8) @(posedge clk);
		#1 resetn = 1'b1;
		repeat (4) @(posedge clk);
		t_reset();
		t_page();
		t_live();
		t_freeze();
		t_rst_mid();
		close_out();
	end
endmodule // tb_top
